/* File: cmp_pkg.sv */
// package: register map, field layout and reset values of the comparator block
package cmp_pkg;
	// ========================================
	// register offsets (byte addresses)
	localparam logic [11:0] CTRL_OFFSET      = 12'h000;
	localparam logic [11:0] IRQ_CTRL_OFFSET  = 12'h004;
	localparam logic [11:0] PORT_OFFSET      = 12'h008;
	localparam logic [11:0] IRQ_STAT_OFFSET  = 12'h00C;
	localparam logic [11:0] IRQ_MASK_OFFSET  = 12'h010;
	// ========================================
	// comparator_control field positions
	localparam int BIT_PIN_FUNC   = 7;
	localparam int BIT_CMP_ON     = 6;
	localparam int BIT_INVERT     = 5;
	localparam int BIT_RESULT     = 4;
	localparam int BIT_ROUTE      = 3;
	localparam int BIT_EDGE_HI    = 2;
	localparam int BIT_EDGE_LO    = 1;
	localparam int BIT_HYST       = 0;
	localparam logic [7:0] CTRL_RESET = 8'h81;
	// ========================================
	// interrupt control field positions
	localparam int BIT_IRQ_FLAG   = 4;
	localparam int BIT_IRQ_EN     = 0;
	localparam int BIT_GLOBAL_EN  = 7;
	// ========================================
	// event status bits: 0 compare change, 1 wake request
	localparam int EV_CHANGE      = 0;
	localparam int EV_WAKE        = 1;
	localparam int EV_COUNT       = 2;
	// ========================================
	// edge selection encodings
	typedef enum logic [1:0] {
		EDGE_RISE = 2'b00,
		EDGE_FALL = 2'b01,
		EDGE_BOTH = 2'b10,
		EDGE_ANY  = 2'b11
	} edge_sel_type;
endpackage

/* File: cmp_sync.sv */
// two flip-flop synchroniser for a single-bit level
`timescale 1ns/10ps
module cmp_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output logic      dout
);
	logic meta_reg;

	// ========================================
	// first stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b0;
			dout     <= 1'b0;
		end else begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule

/* File: cmp_ctrl.sv */
// comparator control, status, interrupt and wake logic with an apb slave
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module cmp_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmp_raw,
	input  wire logic        low_power,
	input  wire logic [1:0]  port_control,
	input  wire logic [1:0]  port_data,
	output logic             analog_enable,
	output logic             hysteresis_enable,
	output logic             input_pins_analog,
	output logic             pull_high_cut,
	output logic             output_pin,
	output logic             output_pin_oe,
	output logic             irq_vector_req,
	output logic             wake,
	output logic             irq
);
	import cmp_pkg::*;

	logic [7:0]          ctrl_reg;
	logic                flag_reg;
	logic                en_reg;
	logic                global_reg;
	logic [EV_COUNT-1:0] stat_reg;
	logic [EV_COUNT-1:0] mask_reg;
	logic                result_reg;
	logic                cmp_sync_out;
	logic                result_next;
	logic                rise;
	logic                fall;
	logic                change_ev;
	logic                wr_en;
	logic                rd_en;
	logic                wr_ctrl;
	logic                wr_irq_ctrl;
	logic                wr_stat;
	logic                wr_mask;
	edge_sel_type        edge_mode;
	logic [EV_COUNT-1:0] ev_vec;
	logic [31:0]         rd_data;
	logic                addr_ok;

	// ========================================
	// synchronised comparator output
	cmp_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (cmp_raw),
		.dout    (cmp_sync_out)
	);

	// ========================================
	// elaboration checks: the layout must fit one bus word per register
	if (EV_COUNT < 1 || EV_COUNT > 32) begin : g_bad_events
		$error("event count does not fit one status register");
	end
	if (CTRL_OFFSET[1:0] != 2'b00 || IRQ_CTRL_OFFSET[1:0] != 2'b00 ||
		PORT_OFFSET[1:0] != 2'b00 || IRQ_STAT_OFFSET[1:0] != 2'b00 ||
		IRQ_MASK_OFFSET[1:0] != 2'b00) begin : g_bad_offsets
		$error("register offsets must be word aligned");
	end
	// the global enable shares a word with the flag and its enable
	if (BIT_GLOBAL_EN == BIT_IRQ_FLAG ||
		BIT_GLOBAL_EN == BIT_IRQ_EN) begin : g_bad_irq_fields
		$error("interrupt control fields overlap");
	end

	// edge type check; both 1x codes take either edge
	function automatic logic edge_hit(input edge_sel_type sel,
		input logic r, input logic f);
		edge_hit = 1'b0;
		unique case (sel)
			EDGE_RISE: edge_hit = r;
			EDGE_FALL: edge_hit = f;
			EDGE_BOTH: edge_hit = r | f;
			EDGE_ANY:  edge_hit = r | f;
		endcase
	endfunction

	// address match, shared by the decode and every write strobe
	function automatic logic reg_hit(input logic [11:0] addr,
		input logic [11:0] offset);
		reg_hit = (addr == offset);
	endfunction

	// ========================================
	// apb decode: one access cycle after each setup, no wait states
	assign wr_en = psel & penable & pwrite;
	// reads are fetched at setup so the data stands in the access cycle
	assign rd_en = psel & ~penable & ~pwrite;
	assign addr_ok = reg_hit(paddr, CTRL_OFFSET) ||
		reg_hit(paddr, IRQ_CTRL_OFFSET) || reg_hit(paddr, PORT_OFFSET) ||
		reg_hit(paddr, IRQ_STAT_OFFSET) || reg_hit(paddr, IRQ_MASK_OFFSET);
	// per-register write strobes; an unmapped write matches none
	assign wr_ctrl     = wr_en & reg_hit(paddr, CTRL_OFFSET);
	assign wr_irq_ctrl = wr_en & reg_hit(paddr, IRQ_CTRL_OFFSET);
	assign wr_stat     = wr_en & reg_hit(paddr, IRQ_STAT_OFFSET);
	assign wr_mask     = wr_en & reg_hit(paddr, IRQ_MASK_OFFSET);

	// result: inactive while off, else polarity applied to synced output
	assign result_next = ctrl_reg[BIT_CMP_ON] ?
		(cmp_sync_out ^ ctrl_reg[BIT_INVERT]) : 1'b0;
	// edges taken from the internal result bit, never the pin
	assign rise = result_next & ~result_reg;
	assign fall = ~result_next & result_reg;
	assign edge_mode = edge_sel_type'(ctrl_reg[BIT_EDGE_HI:BIT_EDGE_LO]);
	assign change_ev = edge_hit(edge_mode, rise, fall);
	assign ev_vec[EV_CHANGE] = change_ev;
	assign ev_vec[EV_WAKE]   = change_ev & ~flag_reg & low_power &
		ctrl_reg[BIT_CMP_ON];

	// ========================================
	// control register; result bit is read only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_reg <= {pwdata[7:5], 1'b0, pwdata[3:0]};
		end
	end

	// result register keeps running in sleep or idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_reg <= 1'b0;
		end else begin
			result_reg <= result_next;
		end
	end

	// ========================================
	// interrupt control: flag set wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg   <= 1'b0;
			en_reg     <= 1'b0;
			global_reg <= 1'b0;
		end else begin
			if (wr_irq_ctrl) begin
				flag_reg   <= pwdata[BIT_IRQ_FLAG] | change_ev;
				en_reg     <= pwdata[BIT_IRQ_EN];
				global_reg <= pwdata[BIT_GLOBAL_EN];
			end else if (change_ev) begin
				flag_reg <= 1'b1;
			end
		end
	end

	// ========================================
	// sticky event status, write one to clear, set wins
	generate
		for (genvar i = 0; i < EV_COUNT; i++) begin : g_stat
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					stat_reg[i] <= 1'b0;
				end else if (ev_vec[i]) begin
					stat_reg[i] <= 1'b1;
				end else if (wr_stat && pwdata[i]) begin
					stat_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= '0;
		end else if (wr_mask) begin
			mask_reg <= pwdata[EV_COUNT-1:0];
		end
	end

	// ========================================
	// read mux; the port view follows the shared-pin rule
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (paddr)
			CTRL_OFFSET: begin
				rd_data[7:0] = ctrl_reg;
				rd_data[BIT_RESULT] = result_reg;
			end
			IRQ_CTRL_OFFSET: begin
				rd_data[BIT_IRQ_FLAG]  = flag_reg;
				rd_data[BIT_IRQ_EN]    = en_reg;
				rd_data[BIT_GLOBAL_EN] = global_reg;
			end
			PORT_OFFSET: begin
				if (ctrl_reg[BIT_CMP_ON] || ctrl_reg[BIT_PIN_FUNC]) begin
					rd_data[1:0] = port_data & ~port_control;
				end else begin
					rd_data[1:0] = port_data;
				end
			end
			IRQ_STAT_OFFSET: rd_data[EV_COUNT-1:0] = stat_reg;
			IRQ_MASK_OFFSET: rd_data[EV_COUNT-1:0] = mask_reg;
			default: rd_data = 32'h0000_0000;
		endcase
	end

	// ========================================
	// registered bus answer: ready stands for the access cycle only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & ~penable;
		end
	end

	// refusal travels with ready, so a bad address is never silent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel & ~penable & ~addr_ok;
		end
	end

	// read data loaded at setup and held, so it stands with ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= rd_data;
		end
	end

	// ========================================
	// analog power switch; off also forces the result low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_enable <= 1'b0;
		end else begin
			analog_enable <= ctrl_reg[BIT_CMP_ON];
		end
	end

	// hysteresis feedback switch for the front end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hysteresis_enable <= 1'b0;
		end else begin
			hysteresis_enable <= ctrl_reg[BIT_HYST];
		end
	end

	// shared pins handed to the comparator inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_pins_analog <= 1'b0;
		end else begin
			input_pins_analog <= ctrl_reg[BIT_PIN_FUNC];
		end
	end

	// pull-highs dropped whenever the pins are analog or powered;
	// a pull-high on a live input would shift the trip point
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pull_high_cut <= 1'b0;
		end else begin
			pull_high_cut <= ctrl_reg[BIT_PIN_FUNC] |
				ctrl_reg[BIT_CMP_ON];
		end
	end

	// pin level follows the internal result; the enable gates it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_pin <= 1'b0;
		end else begin
			output_pin <= result_next;
		end
	end

	// the pin is driven only when routed out and the pins are analog
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_pin_oe <= 1'b0;
		end else begin
			output_pin_oe <= ~ctrl_reg[BIT_ROUTE] &
				ctrl_reg[BIT_PIN_FUNC];
		end
	end

	// ========================================
	// vector request needs flag, enable and the global enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_vector_req <= 1'b0;
		end else begin
			irq_vector_req <= flag_reg & en_reg & global_reg;
		end
	end

	// wake is a one-cycle pulse; a preset flag suppresses it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake <= 1'b0;
		end else begin
			wake <= ev_vec[EV_WAKE];
		end
	end

	// combined level interrupt from unmasked sticky events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_reg & mask_reg);
		end
	end
endmodule

/* File: cmp_checker.sv */
// checker: apb answer and control output assertions for cmp_ctrl
`timescale 1ns/10ps
module cmp_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        low_power,
	input wire logic        analog_enable,
	input wire logic        input_pins_analog,
	input wire logic        pull_high_cut,
	input wire logic        output_pin_oe,
	input wire logic        wake
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ========================================
	// apb answer steps: one wait-free access after each setup
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	a_answer_once: assert property (s_setup |=> s_answer)
		else $error("setup not answered by one ready pulse");
	a_ready_cause: assert property (pready |-> $past(psel && !penable))
		else $error("ready without a setup cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error outside access cycle");
	a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	// ========================================
	// pin ownership and wake
	a_pull_cut: assert property (
		pull_high_cut == (input_pins_analog || analog_enable))
		else $error("pull-high cut mismatch");
	a_oe_sel: assert property (output_pin_oe |-> input_pins_analog)
		else $error("output pin driven while pins are port");
	a_wake_one: assert property (wake |=> !wake)
		else $error("wake longer than one cycle");
	a_wake_sleep: assert property (
		wake |-> $past(low_power) && analog_enable)
		else $error("wake outside sleep or with comparator off");
endmodule

bind cmp_ctrl cmp_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr, .low_power, .analog_enable,
	.input_pins_analog, .pull_high_cut, .output_pin_oe, .wake);

/* File: cmp_analog.sv */
// model of the two analog inputs and the comparator front end
`timescale 1ns/10ps
module cmp_analog (
	input var int     pos,
	input var int     neg,
	input wire logic  hyst,
	output logic      cmp_raw
);
	// with hysteresis the decision holds inside a band of 5 either side of the trip
	always @* begin
		if (pos > neg + (hyst ? 5 : 0)) cmp_raw = 1'b1;
		else if (pos < neg - (hyst ? 5 : 0)) cmp_raw = 1'b0;
	end
endmodule

/* File: tb.sv */
// testbench: registers, edges, interrupts, wake and port view
`timescale 1ns/10ps
module tb;
	import cmp_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        cmp_raw, low_power, analog_enable, hysteresis_enable;
	logic        input_pins_analog, pull_high_cut, output_pin, output_pin_oe;
	logic        irq_vector_req, wake, irq;
	logic [1:0]  port_control, port_data;
	logic [32:0] e;
	logic [32:0] q[$];
	int          pos, neg, num_errors, n_compared, nw, t;
	cmp_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cmp_raw, .low_power,
		.port_control, .port_data, .analog_enable, .hysteresis_enable,
		.input_pins_analog, .pull_high_cut, .output_pin, .output_pin_oe,
		.irq_vector_req, .wake, .irq);
	cmp_analog ana (.pos, .neg, .hyst(hysteresis_enable), .cmp_raw);
	// ========================================
	// shared tasks
	task check(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task chk1(input logic s, input logic x);
		check({32'h0, s}, {32'h0, x});
	endtask
	// request held until the edge where ready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0; penable <= 1'b0;
		// idle edge so a following call never reassigns psel at once
		@(posedge pclk);
	endtask
	task rd(input logic [11:0] a, input logic [32:0] x);
		q.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// margins stay well outside the hysteresis band
	task vin(input logic hi);
		pos <= hi ? 110 + $urandom % 50 : $urandom % 90;
		wt(5);
	endtask
	task td;
		t++;
		$display("test %0d done", t);
	endtask
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ========================================
	// clock, read monitor, wake counter, watchdog
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = q.pop_front();
			check({pslverr, prdata}, e);
		end
		if (wake === 1'b1) nw++;
	end
	initial begin
		#100000;
		num_errors++;
		print_verdict;
	end
	// ========================================
	// main sequence
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
		pwdata = 0; low_power = 0; port_control = 0; port_data = 0;
		pos = 0; neg = 100; num_errors = 0; n_compared = 0; nw = 0; t = 0;
		void'($urandom(11));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		wt(3);
		rd(CTRL_OFFSET, 33'h81);
		rd(IRQ_CTRL_OFFSET, 33'h0);
		chk1(input_pins_analog, 1'b1);
		chk1(hysteresis_enable, 1'b1);
		chk1(analog_enable, 1'b0);
		vin(1'b1);
		rd(CTRL_OFFSET, 33'h81);
		td;
		for (int s = 0; s < 4; s++) begin
			vin(1'b0);
			apb(1'b1, CTRL_OFFSET, 32'h0000_00C0 | 32'(s << 1));
			apb(1'b1, IRQ_CTRL_OFFSET, 32'h0);
			vin(1'b1);
			rd(IRQ_CTRL_OFFSET, {28'h0, s != 1, 4'h0});
			apb(1'b1, IRQ_CTRL_OFFSET, 32'h0);
			vin(1'b0);
			rd(IRQ_CTRL_OFFSET, {28'h0, s != 0, 4'h0});
		end
		td;
		vin(1'b1);
		apb(1'b1, CTRL_OFFSET, 32'h0000_00C0);
		wt(5);
		rd(CTRL_OFFSET, 33'hD0);
		chk1(output_pin, 1'b1);
		chk1(output_pin_oe, 1'b1);
		apb(1'b1, CTRL_OFFSET, 32'h0000_00F0);
		wt(5);
		rd(CTRL_OFFSET, 33'hE0);
		chk1(output_pin, 1'b0);
		apb(1'b1, CTRL_OFFSET, 32'h0000_0048);
		wt(2);
		chk1(output_pin_oe, 1'b0);
		chk1(input_pins_analog, 1'b0);
		chk1(pull_high_cut, 1'b1);
		chk1(hysteresis_enable, 1'b0);
		chk1(analog_enable, 1'b1);
		port_control <= 2'($urandom);
		port_data <= 2'($urandom);
		wt(2);
		rd(PORT_OFFSET, {31'h0, port_data & ~port_control});
		apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
		rd(PORT_OFFSET, {31'h0, port_data});
		chk1(analog_enable, 1'b0);
		chk1(pull_high_cut, 1'b0);
		td;
		apb(1'b1, IRQ_CTRL_OFFSET, 32'h0000_0011);
		wt(2);
		chk1(irq_vector_req, 1'b0);
		rd(IRQ_CTRL_OFFSET, 33'h11);
		apb(1'b1, IRQ_CTRL_OFFSET, 32'h0000_0091);
		wt(2);
		chk1(irq_vector_req, 1'b1);
		apb(1'b1, CTRL_OFFSET, 32'h0000_00C4);
		apb(1'b1, IRQ_MASK_OFFSET, 32'h0);
		apb(1'b1, IRQ_STAT_OFFSET, 32'h0000_0003);
		vin(1'b0);
		chk1(irq, 1'b0);
		apb(1'b1, IRQ_MASK_OFFSET, 32'h0000_0001);
		wt(2);
		chk1(irq, 1'b1);
		apb(1'b1, IRQ_STAT_OFFSET, 32'h0000_0001);
		wt(2);
		chk1(irq, 1'b0);
		td;
		apb(1'b1, IRQ_CTRL_OFFSET, 32'h0);
		low_power <= 1'b1;
		vin(1'b1);
		check(33'(nw), 33'h1);
		rd(CTRL_OFFSET, 33'hD4);
		apb(1'b1, IRQ_CTRL_OFFSET, 32'h0000_0010);
		vin(1'b0);
		check(33'(nw), 33'h1);
		low_power <= 1'b0;
		rd(12'h020, 33'h1_0000_0000);
		td;
		print_verdict;
	end
endmodule
